// file: rtl/lvdc_cond_if.sv
`timescale 1ns/1ps
interface lvdc_cond_if;
    logic enable;
    logic below_sync;
    logic below_qualified;

    modport ctrl (output enable, input below_sync, input below_qualified);
    modport cond (input enable, output below_sync, output below_qualified);
endinterface : lvdc_cond_if

// file: rtl/lvdc_condition.sv
`timescale 1ns/1ps
module lvdc_condition #(
    parameter int SET_CYCLES = lvdc_pkg::BELOW_SET_CYCLES
) (
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    input  wire logic   cmp_below_raw,
    lvdc_cond_if.cond   link
);

    localparam int CW = $clog2(SET_CYCLES + 1);

    if (SET_CYCLES < 1)
    begin : g_bad_set_cycles
        $error("SET_CYCLES must be at least 1");
    end

    logic          sync_a;
    logic          sync_b;
    logic [CW-1:0] dwell;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else
        begin
            sync_a <= cmp_below_raw;
            sync_b <= sync_a;
        end
    end

    assign link.below_sync = sync_b;

    // ------------------------------------------------------------
    // Dwell qualifier
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !link.enable || !sync_b)
        begin
            dwell <= '0;
        end
        else if (dwell != CW'(SET_CYCLES))
        begin
            dwell <= dwell + CW'(1);
        end
    end

    assign link.below_qualified = (dwell == CW'(SET_CYCLES));

endmodule : lvdc_condition

// file: rtl/lvdc_pkg.sv
package lvdc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT_TWELVE_DIRECTION = 16'hFF2C;
    localparam logic [15:0] ADDR_DETECT_CONTROL        = 16'hFFBE;
    localparam logic [15:0] ADDR_THRESHOLD_SELECT      = 16'hFFBF;

    localparam logic [7:0]  RST_PORT_TWELVE_DIRECTION  = 8'hFF;
    localparam logic [7:0]  RST_DETECT_CONTROL         = 8'h00;
    localparam logic [7:0]  RST_THRESHOLD_SELECT       = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DETECT_ENABLE  = 7;
    localparam int BIT_SOURCE_SELECT  = 2;
    localparam int BIT_RESPONSE_MODE  = 1;
    localparam int BIT_BELOW_FLAG     = 0;
    localparam int CODE_MSB           = 3;
    localparam int DIR_PIN_COUNT      = 5;
    localparam logic [7:0] DIR_FIXED_ONES = 8'hE0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ             = 20_000_000;
    localparam int BELOW_SET_US       = 200;
    localparam int BELOW_SET_CYCLES   = (BELOW_SET_US * (CLK_HZ / 1_000_000));

endpackage : lvdc_pkg

// file: rtl/lvdc_top.sv
// Function
// - Comparator runs only while control bit 7 is set.
// - Bit 2 picks supply voltage (0) or external sense pin (1).
// - Mode bit 0: interrupt on falling below and on returning above.
// - Mode bit 1: hold internal reset while below threshold.
// - Flag is 1 while below; 0 when above or disabled.
// - Control bit 0 is read-only; writes do not touch it.
// - Detector reset keeps control bits; other resets clear control to 00H.
// - Detector reset keeps threshold code; other resets clear it to 00H.
// - All three registers take single-bit and whole-byte writes.
// - Flag sets no sooner than 200 us after going below.
// - Interrupt mode: clearing enable while below raises the interrupt.
// - Four-bit code picks one of 16 supply thresholds, 4.24 V to 1.93 V.
// - External source compares against fixed 1.21 V, code ignored.
// - Every reset sets direction to FFH; bits 7 to 5 read 1.
// - Detector reset sets bit 0 of the reset cause register.
`timescale 1ns/1ps
module lvdc_top #(
    parameter int SET_CYCLES = lvdc_pkg::BELOW_SET_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        reset_by_monitor,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr_byte,
    input  wire logic        bus_wr_bit,
    input  wire logic [2:0]  bus_bit_sel,
    input  wire logic        bus_bit_val,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    output logic             bus_hit,
    input  wire logic        cmp_below_raw,
    output logic             cmp_enable,
    output logic             use_fixed_reference,
    output logic      [3:0]  supply_threshold_code,
    output logic      [4:0]  port_twelve_output_enable,
    output logic             low_voltage_interrupt,
    output logic             monitor_reset,
    output logic             monitor_reset_cause_set
);

    logic [7:0] detect_control;
    logic [7:0] threshold_select;
    logic [7:0] port_twelve_direction;
    logic       below_threshold_flag;
    logic       flag_q;
    logic       monitor_reset_q;

    lvdc_cond_if cond_link ();

    // ------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lvdc_write_value(
        input logic [7:0] current,
        input logic       byte_wr,
        input logic [2:0] sel,
        input logic       val,
        input logic [7:0] data
    );
        logic [7:0] result;
        result = current;
        if (byte_wr)
        begin
            result = data;
        end
        else
        begin
            result[sel] = val;
        end
        return result;
    endfunction : lvdc_write_value

    logic       wr_any;
    logic       wr_ctrl;
    logic       wr_thr;
    logic       wr_dir;
    logic [7:0] next_detect_control;
    logic [7:0] next_threshold_select;
    logic [7:0] next_port_twelve_direction;

    assign wr_any  = bus_wr_byte | bus_wr_bit;
    assign wr_ctrl = wr_any && (bus_addr == lvdc_pkg::ADDR_DETECT_CONTROL);
    assign wr_thr  = wr_any && (bus_addr == lvdc_pkg::ADDR_THRESHOLD_SELECT);
    assign wr_dir  = wr_any && (bus_addr == lvdc_pkg::ADDR_PORT_TWELVE_DIRECTION);

    assign bus_hit = (bus_addr == lvdc_pkg::ADDR_DETECT_CONTROL)
                  || (bus_addr == lvdc_pkg::ADDR_THRESHOLD_SELECT)
                  || (bus_addr == lvdc_pkg::ADDR_PORT_TWELVE_DIRECTION);

    always_comb
    begin
        next_detect_control = lvdc_write_value(detect_control, bus_wr_byte,
                                               bus_bit_sel, bus_bit_val, bus_wdata);
        next_detect_control[lvdc_pkg::BIT_BELOW_FLAG] = 1'b0;
        next_detect_control[6:3] = 4'h0;
        next_threshold_select = lvdc_write_value(threshold_select, bus_wr_byte,
                                                 bus_bit_sel, bus_bit_val, bus_wdata);
        next_port_twelve_direction = lvdc_write_value(port_twelve_direction,
                                                      bus_wr_byte, bus_bit_sel,
                                                      bus_bit_val, bus_wdata)
                                   | lvdc_pkg::DIR_FIXED_ONES;
    end

    // ------------------------------------------------------------
    // Detect control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            if (!reset_by_monitor)
            begin
                detect_control <= lvdc_pkg::RST_DETECT_CONTROL;
            end
        end
        else if (wr_ctrl)
        begin
            detect_control <= next_detect_control;
        end
    end

    // ------------------------------------------------------------
    // Threshold select register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            if (!reset_by_monitor)
            begin
                threshold_select <= lvdc_pkg::RST_THRESHOLD_SELECT;
            end
        end
        else if (wr_thr)
        begin
            threshold_select <= next_threshold_select;
        end
    end

    // ------------------------------------------------------------
    // Port twelve direction register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            port_twelve_direction <= lvdc_pkg::RST_PORT_TWELVE_DIRECTION;
        end
        else if (wr_dir)
        begin
            port_twelve_direction <= next_port_twelve_direction;
        end
    end

    assign port_twelve_output_enable =
        ~port_twelve_direction[lvdc_pkg::DIR_PIN_COUNT-1:0];

    // ------------------------------------------------------------
    // Comparator control
    // ------------------------------------------------------------
    assign cmp_enable          = detect_control[lvdc_pkg::BIT_DETECT_ENABLE];
    assign use_fixed_reference = detect_control[lvdc_pkg::BIT_SOURCE_SELECT];
    assign supply_threshold_code = use_fixed_reference ? 4'h0
                                 : threshold_select[lvdc_pkg::CODE_MSB:0];
    assign cond_link.enable    = cmp_enable;

    lvdc_condition #(
        .SET_CYCLES (SET_CYCLES)
    ) u_condition (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .cmp_below_raw (cmp_below_raw),
        .link          (cond_link)
    );

    // Synchronised level also gates the flag, so release is not held by the counter
    assign below_threshold_flag = cmp_enable & cond_link.below_qualified
                                & cond_link.below_sync;

    // ------------------------------------------------------------
    // Interrupt and reset outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            flag_q                <= 1'b0;
            low_voltage_interrupt <= 1'b0;
        end
        else
        begin
            flag_q <= below_threshold_flag;
            // Flag drops on disable, so a falling edge covers clearing while below
            low_voltage_interrupt <= !detect_control[lvdc_pkg::BIT_RESPONSE_MODE]
                                  && (below_threshold_flag != flag_q)
                                  && (cmp_enable || flag_q);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            monitor_reset           <= 1'b0;
            monitor_reset_q         <= 1'b0;
            monitor_reset_cause_set <= 1'b0;
        end
        else
        begin
            monitor_reset <= detect_control[lvdc_pkg::BIT_RESPONSE_MODE]
                          && below_threshold_flag;
            monitor_reset_q <= monitor_reset;
            monitor_reset_cause_set <= monitor_reset && !monitor_reset_q;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            bus_rdata <= 8'h00;
        end
        else if (bus_rd)
        begin
            case (bus_addr)
                lvdc_pkg::ADDR_DETECT_CONTROL:
                    bus_rdata <= {detect_control[7:1], below_threshold_flag};
                lvdc_pkg::ADDR_THRESHOLD_SELECT:
                    bus_rdata <= threshold_select;
                lvdc_pkg::ADDR_PORT_TWELVE_DIRECTION:
                    bus_rdata <= port_twelve_direction | lvdc_pkg::DIR_FIXED_ONES;
                default:
                    bus_rdata <= 8'h00;
            endcase
        end
    end

endmodule : lvdc_top

// file: sim/lvdc_top_properties.sv
`timescale 1ns/1ps
// --------------------------
// Checker for detector block
// --------------------------
module lvdc_top_properties #(
    parameter int SET_CYCLES = 8
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_rd,
    input wire logic [7:0]  bus_rdata,
    input wire logic        bus_hit,
    input wire logic        cmp_below_raw,
    input wire logic        cmp_enable,
    input wire logic        use_fixed_reference,
    input wire logic [3:0]  supply_threshold_code,
    input wire logic [4:0]  port_twelve_output_enable,
    input wire logic        low_voltage_interrupt,
    input wire logic        monitor_reset,
    input wire logic        monitor_reset_cause_set
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [15:0] raw_run;
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !cmp_below_raw)
            raw_run <= 16'h0000;
        else if (raw_run != 16'hFFFF)
            raw_run <= raw_run + 16'h0001;
    end
    sequence s_raw_quiet;
        (!cmp_below_raw)[*6];
    endsequence
    sequence s_off;
        (!cmp_enable)[*3];
    endsequence
    a_dir_reset:
        assert property ($rose(reset_n) |-> port_twelve_output_enable == 5'h00)
        else $error("direction not input");
    a_irq_pulse:
        assert property (low_voltage_interrupt |=> !low_voltage_interrupt)
        else $error("interrupt too long");
    a_irq_enabled:
        assert property (low_voltage_interrupt |-> $past(cmp_enable, 2))
        else $error("interrupt while disabled");
    a_rst_dwell:
        assert property ($rose(monitor_reset) |-> raw_run >= SET_CYCLES)
        else $error("reset too early");
    a_rst_release:
        assert property (s_raw_quiet |-> !monitor_reset)
        else $error("reset not released");
    a_rst_off:
        assert property (s_off |-> !monitor_reset)
        else $error("reset while disabled");
    a_cause_pulse:
        assert property ($rose(monitor_reset) |-> ##[0:1] monitor_reset_cause_set)
        else $error("cause not set");
    a_cause_only:
        assert property (monitor_reset_cause_set |-> monitor_reset && !$past(monitor_reset, 2))
        else $error("stray cause");
    a_fixed_code:
        assert property (use_fixed_reference |-> supply_threshold_code == 4'h0)
        else $error("code not ignored");
    a_bad_read:
        assert property (bus_rd && !bus_hit |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : lvdc_top_properties

bind lvdc_top lvdc_top_properties #(.SET_CYCLES(SET_CYCLES)) chk_u (
    .clk_sys, .reset_n, .bus_addr, .bus_rd, .bus_rdata, .bus_hit, .cmp_below_raw,
    .cmp_enable, .use_fixed_reference, .supply_threshold_code,
    .port_twelve_output_enable, .low_voltage_interrupt, .monitor_reset,
    .monitor_reset_cause_set
);

// file: sim/tb.sv
`timescale 1ns/1ps
// ------------------------
// Bench for detector block
// ------------------------
module tb;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        reset_by_monitor = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic        bus_rd = 1'b0;
    logic        bus_wr_byte = 1'b0;
    logic        bus_wr_bit = 1'b0;
    logic [2:0]  bus_bit_sel = 3'h0;
    logic        bus_bit_val = 1'b0;
    logic [7:0]  bus_wdata = 8'h00;
    logic        cmp_below_raw = 1'b0;
    logic [7:0]  bus_rdata;
    logic [3:0]  supply_threshold_code;
    logic [4:0]  port_twelve_output_enable;
    logic        bus_hit, cmp_enable, use_fixed_reference;
    logic        low_voltage_interrupt, monitor_reset, monitor_reset_cause_set;
    int          fails = 0, cmp_count = 0, cyc = 0, irq_n = 0, cause_n = 0;

    lvdc_top #(.SET_CYCLES(8)) dut_u (
        .clk_sys, .reset_n, .reset_by_monitor, .bus_addr, .bus_rd, .bus_wr_byte,
        .bus_wr_bit, .bus_bit_sel, .bus_bit_val, .bus_wdata, .bus_rdata, .bus_hit,
        .cmp_below_raw, .cmp_enable, .use_fixed_reference, .supply_threshold_code,
        .port_twelve_output_enable, .low_voltage_interrupt, .monitor_reset,
        .monitor_reset_cause_set
    );

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (low_voltage_interrupt === 1'b1) irq_n++;
        if (monitor_reset_cause_set === 1'b1) cause_n++;
        if (cyc == 2000)
        begin
            fails++;
            give_verdict();
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task wr(input logic [15:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr_byte = 1'b1;
        tick(1);
        bus_wr_byte = 1'b0;
        tick(1);
    endtask : wr

    task wbit(input logic [15:0] a, input logic [2:0] s, input logic v);
        bus_addr = a;
        bus_bit_sel = s;
        bus_bit_val = v;
        bus_wr_bit = 1'b1;
        tick(1);
        bus_wr_bit = 1'b0;
        tick(1);
    endtask : wbit

    task rd(input logic [15:0] a, input logic [7:0] exp);
        bus_addr = a;
        bus_rd = 1'b1;
        tick(1);
        bus_rd = 1'b0;
        check(bus_rdata, exp);
        tick(1);
    endtask : rd

    task rst(input logic by);
        reset_n = 1'b0;
        reset_by_monitor = by;
        tick(4);
        reset_n = 1'b1;
        reset_by_monitor = 1'b0;
    endtask : rst

    task t_regs;
        check({3'h0, port_twelve_output_enable}, 8'h00);
        rd(16'hFF2C, 8'hFF);
        rd(16'hFFBE, 8'h00);
        rd(16'hFFBF, 8'h00);
        wr(16'hFF2C, 8'h00);
        rd(16'hFF2C, 8'hE0);
        check({7'h0, bus_hit}, 8'h01);
        check({3'h0, port_twelve_output_enable}, 8'h1F);
        wbit(16'hFF2C, 3'h0, 1'b1);
        rd(16'hFF2C, 8'hE1);
        wr(16'hFFBF, 8'h0A);
        wbit(16'hFFBF, 3'h0, 1'b1);
        rd(16'hFFBF, 8'h0B);
        check({4'h0, supply_threshold_code}, 8'h0B);
        wr(16'hFFBE, 8'h05);
        rd(16'hFFBE, 8'h04);
        check({7'h0, use_fixed_reference}, 8'h01);
        check({4'h0, supply_threshold_code}, 8'h00);
        wr(16'hFFBE, 8'h00);
        wr(16'hFF00, 8'h55);
        rd(16'hFF00, 8'h00);
        check({7'h0, bus_hit}, 8'h00);
    endtask : t_regs

    task t_irq;
        wr(16'hFFBE, 8'h80);
        check({7'h0, cmp_enable}, 8'h01);
        tick(200);
        irq_n = 0;
        cmp_below_raw = 1'b1;
        tick(4);
        cmp_below_raw = 1'b0;
        tick(8);
        check(8'(irq_n), 8'h00);
        cmp_below_raw = 1'b1;
        tick(10);
        check(8'(irq_n), 8'h00);
        tick(6);
        check(8'(irq_n), 8'h01);
        rd(16'hFFBE, 8'h81);
        cmp_below_raw = 1'b0;
        tick(6);
        check(8'(irq_n), 8'h02);
        rd(16'hFFBE, 8'h80);
        cmp_below_raw = 1'b1;
        tick(16);
        wbit(16'hFFBE, 3'h7, 1'b0);
        tick(3);
        check(8'(irq_n), 8'h04);
        rd(16'hFFBE, 8'h00);
        tick(12);
        check(8'(irq_n), 8'h04);
        cmp_below_raw = 1'b0;
    endtask : t_irq

    task t_rst;
        wr(16'hFFBF, 8'h05);
        wr(16'hFFBE, 8'h82);
        tick(200);
        cause_n = 0;
        cmp_below_raw = 1'b1;
        tick(16);
        check({7'h0, monitor_reset}, 8'h01);
        check(8'(cause_n), 8'h01);
        check(8'(irq_n), 8'h04);
        rd(16'hFFBE, 8'h83);
        cmp_below_raw = 1'b0;
        tick(6);
        check({7'h0, monitor_reset}, 8'h00);
        wr(16'hFF2C, 8'h00);
        rst(1'b1);
        rd(16'hFFBE, 8'h82);
        rd(16'hFFBF, 8'h05);
        rd(16'hFF2C, 8'hFF);
        rst(1'b0);
        rd(16'hFFBE, 8'h00);
        rd(16'hFFBF, 8'h00);
    endtask : t_rst

    task give_verdict;
        $display("Mismatches %0d, comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        tick(4);
        reset_n = 1'b1;
        t_regs();
        t_irq();
        t_rst();
        give_verdict();
    end
endmodule : tb
